/* File: src/dcd_regs.svh */
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

// command/address bus width
`define DCD_CA_WIDTH  6
// first-half flag bits on ca[5]
`define DCD_AB_BIT    5
`define DCD_BL_BIT    5
`define DCD_HI_BIT    5
// second-half field positions
`define DCD_AP_BIT    5
`define DCD_C9_BIT    4
`define DCD_R10_BIT   4
`define DCD_R11_BIT   5
`define DCD_BA_MSB    2
// reserved SRE bit must be low
`define DCD_SRE_BIT   5
// deselect slots owed after an mpc without column command
`define DCD_MPC_GAP   2'h2
// value every one-cycle output falls back to each cycle
`define DCD_RST_VAL   1'h0

`endif

/* File: src/dcd_pkg.sv */
package dcd_pkg;

  // decoded first-half command kinds
  typedef enum logic [4:0] {
    DCD_NONE, DCD_MPC, DCD_PRE, DCD_REF, DCD_SRE, DCD_SRX, DCD_WR1, DCD_MWR1,
    DCD_RD1, DCD_CAS2, DCD_MRW1, DCD_MRW2, DCD_MRR1, DCD_ACT1, DCD_ACT2, DCD_RFU
  } dcd_cmd_type;

  // decoder phase
  typedef enum logic {DCD_IDLE, DCD_SECOND} dcd_phase_type;

  // whole state of the core decoder
  typedef struct packed {
    dcd_phase_type phase;
    dcd_cmd_type   firstKind;
    logic [5:0]    firstCa;
    dcd_cmd_type   casOwner;
    logic          needCas;
    logic          needAct2;
    logic          needMrw2;
    logic          mpcOpen;
    logic [1:0]    quiet;
    logic          c9;
    logic          cmdValid;
    dcd_cmd_type   cmdKind;
    logic [2:0]    bank;
    logic          allBank;
    logic          autoPre;
    logic          burstLong;
    logic [9:0]    colAddr;
    logic          colValid;
    logic [14:0]   rowAddr;
    logic          rowValid;
    logic [5:0]    mrAddr;
    logic [7:0]    mrData;
    logic          mrwValid;
    logic [6:0]    mpcOp;
    logic          desPulse;
    logic          cmdErr;
    logic          illegal;
  } dcd_state_type;

  // two synchroniser stages for cs, cke and ca
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } dcd_sync_type;

endpackage

/* File: src/dcd_cmd_if.sv */
`timescale 1ns/1ns
interface dcd_cmd_if;
  import dcd_pkg::*;
  logic        cs;    // synchronised chip select
  logic        cke;   // synchronised clock enable
  logic [5:0]  ca;    // synchronised command/address
  dcd_cmd_type kind;  // first-half classification of ca

  modport syncer  (output cs, output cke, output ca);
  modport decoder (input ca, output kind);
  modport core    (input cs, input cke, input ca, input kind);
endinterface

/* File: src/dcd_pin_sync.sv */
`timescale 1ns/1ns
module dcd_pin_sync #(
  parameter int CA_W = 6
) (
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  input  wire logic  ckePin,
  input  wire logic  csPin,
  input  wire logic [CA_W-1:0] caPin,
  dcd_cmd_if.syncer  bus
);
  import dcd_pkg::*;

  // the packed stage layout fixes the bus at six bits
  if (CA_W != 6) begin : gWidthCheck
    $error("dcd_pin_sync: CA_W must be 6");
  end

  dcd_sync_type st_ff;   // both stages
  dcd_sync_type nxt_st;  // next stages

  // first stage feeds only the second stage
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = {ckePin, csPin, caPin};
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.cke = st_ff.s2[7];
  assign bus.cs  = st_ff.s2[6];
  assign bus.ca  = st_ff.s2[5:0];
endmodule

/* File: src/dcd_first_decode.sv */
`timescale 1ns/1ns
module dcd_first_decode (
  dcd_cmd_if.decoder bus
);
  import dcd_pkg::*;

  // classify ca[4:0]; written msb first, so ca0 is the right-hand bit
  always_comb begin
    casez (bus.ca[4:0])
      5'h00:    bus.kind = DCD_MPC;
      5'h10:    bus.kind = DCD_PRE;
      5'h08:    bus.kind = DCD_REF;
      5'h18:    bus.kind = DCD_SRE;
      5'h14:    bus.kind = DCD_SRX;
      5'h04:    bus.kind = DCD_WR1;
      5'h0c:    bus.kind = DCD_MWR1;
      5'h02:    bus.kind = DCD_RD1;
      5'h12:    bus.kind = DCD_CAS2;
      5'h06:    bus.kind = DCD_MRW1;
      5'h16:    bus.kind = DCD_MRW2;
      5'h0e:    bus.kind = DCD_MRR1;
      5'b???01: bus.kind = DCD_ACT1;
      5'b???11: bus.kind = DCD_ACT2;
      default:  bus.kind = DCD_RFU;
    endcase
  end
endmodule

/* File: src/dcd_cmd_decoder.sv */
// Overview of operation
// - commands take two cycles, deselect one
// - chip select low first edge is deselect
// - kind from first edge, operands from both edges
// - precharge, refresh, self refresh patterns decoded
// - all-bank flag ignores bank address
// - write, masked write, read with bank, C9, AP
// - on-the-fly flag picks burst 32 or 16
// - masked write only burst 16, CA5 low
// - column command carries C8 then C2..C7
// - C1..C0 zero; writes drive C3..C2 low
// - mpc decode; no column means two deselects
// - mode-register write halves carry address, data
// - mode read then column command immediately
// - activate halves carry bank and row bits
// - inputs sampled on rising clock edge
`timescale 1ns/1ns
`include "dcd_regs.svh"
module dcd_cmd_decoder #(
  parameter int CA_W = `DCD_CA_WIDTH
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               ckePin,
  input  wire logic               csPin,
  input  wire logic [CA_W-1:0]    caPin,
  input  wire logic               otfBurstEn,
  output logic                    cmdValid,
  output dcd_pkg::dcd_cmd_type    cmdKind,
  output logic [2:0]              bank,
  output logic                    allBank,
  output logic                    autoPre,
  output logic                    burstLong,
  output logic                    colValid,
  output logic [9:0]              colAddr,
  output logic                    rowValid,
  output logic [14:0]             rowAddr,
  output logic [5:0]              mrAddr,
  output logic                    mrwValid,
  output logic [7:0]              mrData,
  output logic [6:0]              mpcOp,
  output logic                    desPulse,
  output logic                    cmdErr,
  output logic                    illegal
);
  import dcd_pkg::*;

  // the field layout only fits a six-bit bus
  if (CA_W != `DCD_CA_WIDTH) begin : gWidthCheck
    $error("dcd_cmd_decoder: CA_W must be 6");
  end

  dcd_cmd_if     bus ();  // synchronised pins plus first-half kind
  dcd_state_type st_ff;   // whole decoder state
  dcd_state_type nxt_st;  // next state

  // pins pass two flops before any decode
  dcd_pin_sync #(.CA_W(CA_W)) uSync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ckePin  (ckePin),
    .csPin   (csPin),
    .caPin   (caPin),
    .bus     (bus.syncer)
  );

  // pattern lookup for the first edge
  dcd_first_decode uDecode (
    .bus (bus.decoder)
  );

  // main decode: first half latched, second half completes the command
  always_comb begin
    logic err;      // this cycle breaks a bus rule
    logic isCas;    // first half is the column command
    logic isWrite;  // pending column owner is a write
    err           = 1'b0;
    isCas         = (bus.kind == DCD_CAS2);
    isWrite       = (st_ff.casOwner == DCD_WR1) || (st_ff.casOwner == DCD_MWR1);
    nxt_st        = st_ff;
    // one-cycle outputs fall back every cycle
    nxt_st.cmdValid = `DCD_RST_VAL;
    nxt_st.colValid = `DCD_RST_VAL;
    nxt_st.rowValid = `DCD_RST_VAL;
    nxt_st.mrwValid = `DCD_RST_VAL;
    nxt_st.desPulse = `DCD_RST_VAL;
    case (st_ff.phase)
      DCD_IDLE: begin
        if (bus.cs) begin
          nxt_st.firstKind = bus.kind;
          nxt_st.firstCa   = bus.ca;
          nxt_st.phase     = DCD_SECOND;
          if (!bus.cke) begin
            err = 1'b1;
          end
          if ((st_ff.needCas || st_ff.mpcOpen) != isCas) begin
            err = 1'b1;
          end
          if (st_ff.needAct2 != (bus.kind == DCD_ACT2)) begin
            err = 1'b1;
          end
          if (st_ff.needMrw2 != (bus.kind == DCD_MRW2)) begin
            err = 1'b1;
          end
          if (st_ff.quiet != 2'h0) begin
            err = 1'b1;
          end
          if (bus.kind == DCD_RFU) begin
            err = 1'b1;
          end
          if ((bus.kind == DCD_MWR1) && bus.ca[`DCD_BL_BIT]) begin
            err = 1'b1;
          end
          // self refresh entry needs CA5 low
          if ((bus.kind == DCD_SRE) && bus.ca[`DCD_SRE_BIT]) begin
            err = 1'b1;
          end
          // mode read also waits for the column command
          nxt_st.needCas  = (bus.kind == DCD_WR1) || (bus.kind == DCD_MWR1) ||
                            (bus.kind == DCD_RD1) || (bus.kind == DCD_MRR1);
          nxt_st.needAct2 = (bus.kind == DCD_ACT1);
          nxt_st.needMrw2 = (bus.kind == DCD_MRW1);
          nxt_st.mpcOpen  = 1'b0;
          nxt_st.quiet    = 2'h0;
          if (nxt_st.needCas) begin
            nxt_st.casOwner = bus.kind;
          end
        end else begin
          nxt_st.desPulse = 1'b1;
          // a pending second half may not be split by a deselect
          if (st_ff.needCas || st_ff.needAct2 || st_ff.needMrw2) begin
            err = 1'b1;
          end
          nxt_st.needCas  = 1'b0;
          nxt_st.needAct2 = 1'b0;
          nxt_st.needMrw2 = 1'b0;
          // count deselects owed after an mpc
          if (st_ff.mpcOpen) begin
            nxt_st.mpcOpen = 1'b0;
            nxt_st.quiet   = `DCD_MPC_GAP - 2'h1;
          end else if (st_ff.quiet != 2'h0) begin
            nxt_st.quiet = st_ff.quiet - 2'h1;
          end
        end
      end
      DCD_SECOND: begin
        nxt_st.phase    = DCD_IDLE;
        nxt_st.cmdValid = 1'b1;
        nxt_st.cmdKind  = st_ff.firstKind;
        // chip select must be low on second edge
        if (bus.cs || !bus.cke) begin
          err = 1'b1;
        end
        // bits marked valid are simply not looked at
        case (st_ff.firstKind)
          DCD_PRE, DCD_REF: begin
            nxt_st.allBank = st_ff.firstCa[`DCD_AB_BIT];
            nxt_st.bank    = st_ff.firstCa[`DCD_AB_BIT] ? 3'h0 : bus.ca[`DCD_BA_MSB:0];
          end
          DCD_WR1, DCD_MWR1, DCD_RD1: begin
            nxt_st.bank    = bus.ca[`DCD_BA_MSB:0];
            nxt_st.c9      = bus.ca[`DCD_C9_BIT];
            nxt_st.autoPre = bus.ca[`DCD_AP_BIT];
            nxt_st.allBank = 1'b0;
            nxt_st.burstLong = otfBurstEn && st_ff.firstCa[`DCD_BL_BIT] &&
                               (st_ff.firstKind != DCD_MWR1);
          end
          DCD_CAS2: begin
            // C9, C8, C7..C2, and C1..C0 zero
            nxt_st.colAddr  = {st_ff.c9, st_ff.firstCa[`DCD_HI_BIT], bus.ca, 2'h0};
            nxt_st.colValid = 1'b1;
            if (isWrite && (bus.ca[1:0] != 2'h0)) begin
              err = 1'b1;
            end
            nxt_st.casOwner = DCD_NONE;
          end
          DCD_MPC: begin
            nxt_st.mpcOp   = {st_ff.firstCa[`DCD_HI_BIT], bus.ca};
            nxt_st.mpcOpen = 1'b1;
          end
          DCD_MRW1: begin
            nxt_st.mrAddr    = bus.ca;
            nxt_st.mrData[7] = st_ff.firstCa[`DCD_HI_BIT];
          end
          DCD_MRW2: begin
            nxt_st.mrData[6:0] = {st_ff.firstCa[`DCD_HI_BIT], bus.ca};
            nxt_st.mrwValid    = 1'b1;
          end
          DCD_MRR1: begin
            nxt_st.mrAddr = bus.ca;
          end
          DCD_ACT1: begin
            nxt_st.bank           = bus.ca[`DCD_BA_MSB:0];
            nxt_st.rowAddr[14:12] = st_ff.firstCa[4:2];
            nxt_st.rowAddr[11]    = bus.ca[`DCD_R11_BIT];
            nxt_st.rowAddr[10]    = bus.ca[`DCD_R10_BIT];
          end
          DCD_ACT2: begin
            nxt_st.rowAddr[9:6] = st_ff.firstCa[5:2];
            nxt_st.rowAddr[5:0] = bus.ca;
            nxt_st.rowValid     = 1'b1;
          end
          default: begin
            // self refresh and reserved carry no operands
            nxt_st.allBank = st_ff.allBank;
          end
        endcase
      end
      default: begin
        nxt_st.phase = DCD_IDLE;
      end
    endcase
    // illegal stays set until reset, since only re-init recovers; cmdErr follows this cycle only
    nxt_st.cmdErr  = err;
    nxt_st.illegal = st_ff.illegal | err;
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every output straight from the state flops
  assign cmdValid  = st_ff.cmdValid;
  assign cmdKind   = st_ff.cmdKind;
  assign bank      = st_ff.bank;
  assign allBank   = st_ff.allBank;
  assign autoPre   = st_ff.autoPre;
  assign burstLong = st_ff.burstLong;
  assign colValid  = st_ff.colValid;
  assign colAddr   = st_ff.colAddr;
  assign rowValid  = st_ff.rowValid;
  assign rowAddr   = st_ff.rowAddr;
  assign mrAddr    = st_ff.mrAddr;
  assign mrwValid  = st_ff.mrwValid;
  assign mrData    = st_ff.mrData;
  assign mpcOp     = st_ff.mpcOp;
  assign desPulse  = st_ff.desPulse;
  assign cmdErr    = st_ff.cmdErr;
  assign illegal   = st_ff.illegal;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sticky_illegal_a: assert property (illegal |=> illegal)
    else $error("illegal flag dropped without reset");
  cke_low_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs && !bus.cke) |=> cmdErr ##0 illegal)
    else $error("command with clock enable low not flagged");
  two_cycle_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs) |=> !cmdValid ##1 cmdValid)
    else $error("command did not complete on second edge");
  deselect_pulse_a: assert property ((st_ff.phase == DCD_IDLE && !bus.cs) |=> desPulse && !cmdValid)
    else $error("deselect not reported");
  second_cs_a: assert property ((st_ff.phase == DCD_SECOND && bus.cs) |=> cmdErr)
    else $error("chip select high on second edge not flagged");
  all_bank_a: assert property ((cmdValid && allBank && (cmdKind == DCD_PRE || cmdKind == DCD_REF))
                               |-> bank == 3'h0)
    else $error("bank address not ignored for all-bank");
  masked_short_a: assert property ((cmdValid && cmdKind == DCD_MWR1) |-> !burstLong)
    else $error("masked write reported long burst");
  col_low_a: assert property (colValid |-> colAddr[1:0] == 2'h0 && $past(st_ff.phase) == DCD_SECOND)
    else $error("column low bits not zero");
  cas_order_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs && bus.kind == DCD_CAS2 &&
                                 !st_ff.needCas && !st_ff.mpcOpen) |=> cmdErr)
    else $error("unpaired column command not flagged");
  rfu_flag_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs && bus.kind == DCD_RFU) |=> cmdErr)
    else $error("reserved pattern not flagged");
  // an mpc with no column command owes two quiet slots before the next command
  quiet_slot_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs && st_ff.quiet != 2'h0) |=> cmdErr)
    else $error("command inside mpc quiet slots not flagged");
  act_pair_a: assert property ((st_ff.phase == DCD_IDLE && bus.cs && st_ff.needAct2 && bus.kind != DCD_ACT2)
                               |=> cmdErr)
    else $error("missing second activate not flagged");
endmodule

/* File: src/dcd_placeholder_none.sv */
`timescale 1ns/1ns

/* File: bench/dcd_ctrl_model.sv */
`timescale 1ns/1ns
// controller model: one command half per clock, launched 1 ns after the edge
module dcd_ctrl_model (
  input  wire logic        sys_clk,
  output logic             ckePin,
  output logic             csPin,
  output logic [5:0]       caPin
);
  initial begin
    ckePin = 1'h1;
    csPin  = 1'h0;
    caPin  = 6'h00;
  end

  // one half; cke goes low only where a scenario asks for it
  // defined bus levels
  task automatic half(input logic cs, input logic [5:0] ca, input logic cke);
    @(posedge sys_clk);
    #1;
    ckePin = cke;
    csPin  = cs;
    caPin  = ca;
  endtask

  // deselect drives the inverse of the last ca value, so never repeats it
  // bus still driven, chip select low
  task automatic idle;
    half(1'h0, ~caPin, 1'h1);
  endtask
endmodule

/* File: bench/dcd_cmd_decoder_bench.sv */
`timescale 1ns/1ns
module dcd_cmd_decoder_bench;
  import dcd_pkg::*;
  localparam logic [5:0] EV_NO  = 6'h00;  // no extra pulse
  localparam logic [5:0] EV_COL = 6'h02;  // column pulse
  localparam logic [5:0] EV_ROW = 6'h04;  // row pulse
  localparam logic [5:0] EV_MRW = 6'h08;  // mode write pulse
  localparam logic [5:0] EV_ERR = 6'h20;  // bus rule error pulse
  logic        sys_clk;       // 10 MHz clock
  logic        rstn;          // async reset, active low
  logic        otfBurstEn;    // on-the-fly burst enable
  logic        ckePin;        // pins driven by the controller model
  logic        csPin;
  logic [5:0]  caPin;
  logic        cmdValid;
  dcd_cmd_type cmdKind;
  logic [2:0]  bank;
  logic        allBank, autoPre, burstLong, colValid, rowValid, mrwValid;
  logic [9:0]  colAddr;
  logic [14:0] rowAddr;
  logic [5:0]  mrAddr;
  logic [7:0]  mrData;
  logic [6:0]  mpcOp;
  logic        desPulse, cmdErr, illegal;
  int          cyc = 0;       // rising edges seen
  int          errCount;      // mismatches
  int          nTests;        // comparisons
  logic        monOn;         // pulse monitor armed
  logic [5:0]  expEv [4096];  // expected {err,des,mrw,row,col,cmd} per edge
  dcd_cmd_type expKind [4096];

  dcd_ctrl_model dcd_ctrl_model_inst (.sys_clk(sys_clk), .ckePin(ckePin), .csPin(csPin), .caPin(caPin));

  dcd_cmd_decoder #(.CA_W(6)) dcd_cmd_decoder_inst (
    .sys_clk(sys_clk), .rstn(rstn), .ckePin(ckePin), .csPin(csPin), .caPin(caPin),
    .otfBurstEn(otfBurstEn), .cmdValid(cmdValid), .cmdKind(cmdKind), .bank(bank),
    .allBank(allBank), .autoPre(autoPre), .burstLong(burstLong), .colValid(colValid),
    .colAddr(colAddr), .rowValid(rowValid), .rowAddr(rowAddr), .mrAddr(mrAddr),
    .mrwValid(mrwValid), .mrData(mrData), .mpcOp(mpcOp), .desPulse(desPulse),
    .cmdErr(cmdErr), .illegal(illegal)
  );

  // clock and edge counter
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // single comparison point
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic complete_run;
    if (errCount == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one half; its pulses land two edges after the sampling edge
  task automatic put(input logic cs, input logic [5:0] ca, input logic [5:0] ev, input logic cke);
    dcd_ctrl_model_inst.half(cs, ca, cke);
    expEv[cyc+3] = expEv[cyc+3] | ev;
  endtask

  // two-cycle command; completion always pulses cmdValid
  task automatic cmd(input logic [5:0] c1, input logic [5:0] c2, input dcd_cmd_type k,
                     input logic [5:0] e1, input logic [5:0] e2);
    put(1'h1, c1, e1, 1'h1);
    put(1'h0, c2, e2 | 6'h01, 1'h1);
    expKind[cyc+3] = k;
  endtask

  // deselects while the decoder is idle
  task automatic des(input int n);
    repeat (n) begin
      dcd_ctrl_model_inst.idle();
      expEv[cyc+3][4] = 1'h1;
    end
  endtask

  // reset for 12 cycles; outputs must read zero meanwhile
  task automatic do_reset;
    monOn = 1'h0;
    @(posedge sys_clk);
    #1;
    rstn = 1'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(16'({cmdValid, colValid, rowValid, mrwValid, desPulse, cmdErr, illegal, cmdKind}), 16'h0);
    chk(16'({mrData, mpcOp}), 16'h0);
    rstn = 1'h1;
    des(4);
    monOn = 1'h1;
  endtask

  // pulse monitor: every pulse output against its fixed latency
  always @(posedge sys_clk) begin
    #2;
    if (monOn) begin
      chk(16'({cmdErr, desPulse, mrwValid, rowValid, colValid, cmdValid}), 16'(expEv[cyc]));
      if (expEv[cyc][0]) chk(16'(cmdKind), 16'(expKind[cyc]));
    end
  end

  // hang guard
  initial begin
    for (int i = 0; i < 2000; i++) @(posedge sys_clk);
    errCount++;
    complete_run();
  end

  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    otfBurstEn = 1'h1;
    monOn = 1'h0;
    errCount = 0;
    nTests = 0;
    foreach (expEv[i]) begin
      expEv[i] = EV_NO;
      expKind[i] = DCD_NONE;
    end
    do_reset();
    cmd(6'h30, 6'h05, DCD_PRE, EV_NO, EV_NO);
    des(3);
    chk(16'({allBank, bank}), 16'h8);
    cmd(6'h08, 6'h03, DCD_REF, EV_NO, EV_NO);
    cmd(6'h18, 6'h2a, DCD_SRE, EV_NO, EV_NO);
    cmd(6'h34, 6'h15, DCD_SRX, EV_NO, EV_NO);
    des(3);
    chk(16'({allBank, bank}), 16'h3);
    cmd(6'h20, 6'h2b, DCD_MPC, EV_NO, EV_NO);
    des(3);
    chk(16'(mpcOp), 16'h6b);
    cmd(6'h24, 6'h36, DCD_WR1, EV_NO, EV_NO);
    cmd(6'h32, 6'h28, DCD_CAS2, EV_NO, EV_COL);
    des(3);
    chk({autoPre, burstLong, allBank, bank, colAddr}, 16'hdba0);
    // burst flag is taken when the first command completes, so switch only once it is idle
    otfBurstEn = 1'h0;
    cmd(6'h22, 6'h01, DCD_RD1, EV_NO, EV_NO);
    cmd(6'h12, 6'h3f, DCD_CAS2, EV_NO, EV_COL);
    des(3);
    chk({autoPre, burstLong, allBank, bank, colAddr}, 16'h04fc);
    otfBurstEn = 1'h1;
    cmd(6'h0c, 6'h02, DCD_MWR1, EV_NO, EV_NO);
    cmd(6'h12, 6'h30, DCD_CAS2, EV_NO, EV_COL);
    des(3);
    chk({autoPre, burstLong, allBank, bank, colAddr}, 16'h08c0);
    cmd(6'h26, 6'h15, DCD_MRW1, EV_NO, EV_NO);
    cmd(6'h16, 6'h2a, DCD_MRW2, EV_NO, EV_MRW);
    des(3);
    chk(16'({mrAddr, mrData}), 16'h15aa);
    // mode read, mpc with column command
    cmd(6'h0e, 6'h33, DCD_MRR1, EV_NO, EV_NO);
    cmd(6'h12, 6'h00, DCD_CAS2, EV_NO, EV_COL);
    cmd(6'h00, 6'h01, DCD_MPC, EV_NO, EV_NO);
    cmd(6'h12, 6'h04, DCD_CAS2, EV_NO, EV_COL);
    des(3);
    chk({mrAddr, 3'h0, mpcOp}, 16'hcc01);
    cmd(6'h35, 6'h24, DCD_ACT1, EV_NO, EV_NO);
    cmd(6'h27, 6'h2d, DCD_ACT2, EV_NO, EV_ROW);
    des(3);
    chk(16'(rowAddr), 16'h5a6d);
    chk(16'({illegal, bank}), 16'h4);
    cmd(6'h1c, 6'h00, DCD_RFU, EV_ERR, EV_NO);
    des(3);
    chk(16'(illegal), 16'h1);
    // long burst flag on masked write
    cmd(6'h2c, 6'h00, DCD_MWR1, EV_ERR, EV_NO);
    cmd(6'h12, 6'h00, DCD_CAS2, EV_NO, EV_COL);
    // masked write column bit three set
    cmd(6'h0c, 6'h00, DCD_MWR1, EV_NO, EV_NO);
    cmd(6'h12, 6'h02, DCD_CAS2, EV_NO, EV_COL | EV_ERR);
    // self refresh entry with CA5 high
    cmd(6'h38, 6'h00, DCD_SRE, EV_ERR, EV_NO);
    // column command with no first half before it
    cmd(6'h12, 6'h00, DCD_CAS2, EV_ERR, EV_COL);
    // chip select high on the second edge
    put(1'h1, 6'h08, EV_NO, 1'h1);
    put(1'h1, 6'h03, EV_ERR | 6'h01, 1'h1);
    expKind[cyc+3] = DCD_REF;
    // command inside the two quiet slots after an mpc
    cmd(6'h00, 6'h01, DCD_MPC, EV_NO, EV_NO);
    des(1);
    cmd(6'h08, 6'h00, DCD_REF, EV_ERR, EV_NO);
    // first activate not followed by the second
    cmd(6'h01, 6'h00, DCD_ACT1, EV_NO, EV_NO);
    cmd(6'h08, 6'h00, DCD_REF, EV_ERR, EV_NO);
    // clock enable low under a command
    put(1'h1, 6'h08, EV_ERR, 1'h0);
    put(1'h0, 6'h00, 6'h01, 1'h1);
    expKind[cyc+3] = DCD_REF;
    des(3);
    chk(16'(illegal), 16'h1);
    // only reset clears the error state
    do_reset();
    des(2);
    chk(16'(illegal), 16'h0);
    complete_run();
  end
endmodule
